// file: src/mbx_responder.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - unsupported function code gets exception code 01.
// - register outside map or overflowing range gets exception code 02.
// - value out of limits or unmodifiable target gets exception code 03.
// - parameter writes while motor runs are refused with exception code 03.
// - exception reply echoes function code with top bit set.
// - code 04 with a wrong address answers 84 then 02 then crc.
// - code 04 with too large a count answers 84 then 03.
// - frame is address, function, data, two-byte crc.
// - 9600 baud, eight data bits, no parity, one stop bit, half duplex.
// - only codes 03 single-word read and 06 single write are supported.
module mbx_responder #(
   parameter int BIT_CYC = mbx_pkg::BIT_CYC,
   parameter int GAP_CYC = mbx_pkg::GAP_CYC,
   parameter int FIFO_DEPTH = 4,
   parameter logic [15:0] READ_MAX = 16'h007d,
   parameter logic [15:0] PARAM_MAX = 16'h03e8
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   // configuration and plant state
   input wire logic [7:0] slave_addr_i,
   input wire logic motor_run_i,
   // rs485 transceiver
   input wire logic rx_i,
   output logic tx_o,
   output logic de_o,
   // accepted request for the normal handler
   output logic req_ok_o,
   output logic [7:0] req_fc_o,
   output logic [15:0] req_addr_o,
   output logic [15:0] req_data_o,
   // last exception sent
   output logic [7:0] exc_code_o
);
   localparam int CW = mbx_pkg::CNT_W;
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYC / 2 - 1);
   localparam logic [CW-1:0] GAP_LAST = CW'(GAP_CYC - 1);

   // map membership, shared by read and write checks
   function automatic logic addr_ok(input logic [15:0] a);
      return (a >= mbx_pkg::REG_CTRL && a <= mbx_pkg::REG_FAULT) ||
             (a >= mbx_pkg::REG_PARAM_LO && a <= mbx_pkg::REG_PARAM_HI) ||
             a == mbx_pkg::REG_RATED_I || a == mbx_pkg::REG_RATED_U ||
             a == mbx_pkg::REG_POWER_U;
   endfunction

   function automatic logic is_param(input logic [15:0] a);
      return a >= mbx_pkg::REG_PARAM_LO && a <= mbx_pkg::REG_PARAM_HI;
   endfunction

   // ============================================================
   // receiver
   mbx_pkg::mbx_rx_t rx_st, next_rst;
   logic [CW-1:0] rcnt, next_rcnt;
   logic [2:0] rbit, next_rbit;
   logic [7:0] rsh, next_rsh;
   logic rdone, next_rdone;

   // mid-bit sampling; our own echo is ignored while the driver is on
   always_comb begin
      next_rst = rx_st;
      next_rcnt = rcnt;
      next_rbit = rbit;
      next_rsh = rsh;
      next_rdone = 1'b0;
      case (rx_st)
         mbx_pkg::RX_IDLE: if (!rx_i && !de_o) begin
            next_rst = mbx_pkg::RX_START;
            next_rcnt = HALF_LAST;
         end
         mbx_pkg::RX_START: if (rcnt == '0) begin
            next_rst = rx_i ? mbx_pkg::RX_IDLE : mbx_pkg::RX_DATA;
            next_rcnt = BIT_LAST;
            next_rbit = 3'h0;
         end else begin
            next_rcnt = rcnt - CW'(1);
         end
         mbx_pkg::RX_DATA: if (rcnt == '0) begin
            next_rsh = {rx_i, rsh[7:1]}; // lsb first, no parity bit
            next_rcnt = BIT_LAST;
            if (rbit == 3'h7) begin
               next_rst = mbx_pkg::RX_STOP;
            end else begin
               next_rbit = rbit + 3'h1;
            end
         end else begin
            next_rcnt = rcnt - CW'(1);
         end
         mbx_pkg::RX_STOP: if (rcnt == '0) begin
            next_rst = mbx_pkg::RX_IDLE;
            next_rdone = rx_i; // framing error drops the byte, crc then fails
         end else begin
            next_rcnt = rcnt - CW'(1);
         end
         default: next_rst = mbx_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rx_st <= mbx_pkg::RX_IDLE;
         rcnt <= '0;
         rbit <= 3'h0;
         rsh <= 8'h00;
         rdone <= 1'b0;
      end else begin
         rx_st <= next_rst;
         rcnt <= next_rcnt;
         rbit <= next_rbit;
         rsh <= next_rsh;
         rdone <= next_rdone;
      end
   end

   // ============================================================
   // request check
   mbx_pkg::mbx_fr_t fst, next_fst;
   logic [7:0] fbuf [0:7];
   logic [7:0] next_fbuf [0:7];
   logic [7:0] rep [0:4];
   logic [7:0] next_rep [0:4];
   logic [3:0] flen, next_flen;
   logic [15:0] fcrc, next_fcrc, rep_crc;
   logic [CW-1:0] gcnt, next_gcnt;
   logic [2:0] pidx, next_pidx;
   logic next_req_ok;
   logic [7:0] next_req_fc, next_exc, code;
   logic [15:0] next_req_addr, next_req_data, raddr, rdata;
   logic discard, is_read, is_write;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [7:0] fifo_out_data;
   mbx_pkg::mbx_tx_t tst, next_tst;

   assign raddr = {fbuf[2], fbuf[3]};
   assign rdata = {fbuf[4], fbuf[5]};
   assign is_read = fbuf[1] == mbx_pkg::FC_READ || fbuf[1] == mbx_pkg::FC_READ_IN;
   assign is_write = fbuf[1] == mbx_pkg::FC_WRITE;
   // a whole-frame crc including its own check bytes leaves zero
   assign discard = fcrc != mbx_pkg::CRC_GOOD || flen < mbx_pkg::MIN_LEN ||
                    fbuf[0] != slave_addr_i;

   // exception choice; the count is judged before the address
   always_comb begin
      code = mbx_pkg::EXC_NONE;
      if (!is_read && !is_write) begin
         code = mbx_pkg::EXC_FUNC;
      end else if (flen != mbx_pkg::FRAME_LEN) begin
         code = mbx_pkg::EXC_VALUE;
      end else if (is_read) begin
         if (rdata > READ_MAX) begin
            code = mbx_pkg::EXC_VALUE;
         end else if (!addr_ok(raddr) || {1'b0, raddr} + {1'b0, rdata} > 17'h10000) begin
            code = mbx_pkg::EXC_ADDR;
         end else if (rdata != mbx_pkg::ONE_WORD) begin
            code = mbx_pkg::EXC_VALUE; // single word only
         end else if (fbuf[1] == mbx_pkg::FC_READ_IN) begin
            code = mbx_pkg::EXC_FUNC;
         end
      end else if (!addr_ok(raddr)) begin
         code = mbx_pkg::EXC_ADDR;
      end else if (raddr != mbx_pkg::REG_CTRL && !is_param(raddr)) begin
         code = mbx_pkg::EXC_VALUE; // read-only target
      end else if (is_param(raddr) && motor_run_i) begin
         code = mbx_pkg::EXC_VALUE;
      end else if (raddr == mbx_pkg::REG_CTRL && (rdata & ~mbx_pkg::CTRL_USED) != 16'h0000) begin
         code = mbx_pkg::EXC_VALUE;
      end else if (is_param(raddr) && rdata > PARAM_MAX) begin
         code = mbx_pkg::EXC_VALUE;
      end
   end

   // reply crc over address, flagged code and exception code
   assign rep_crc = mbx_pkg::mbx_crc_byte(mbx_pkg::mbx_crc_byte(mbx_pkg::mbx_crc_byte(
                    mbx_pkg::CRC_INIT, fbuf[0]), fbuf[1] | mbx_pkg::EXC_FLAG), code);

   // collect, judge, then queue the reply
   always_comb begin
      next_fst = fst;
      next_fbuf = fbuf;
      next_rep = rep;
      next_flen = flen;
      next_fcrc = fcrc;
      next_gcnt = gcnt;
      next_pidx = pidx;
      next_req_ok = 1'b0;
      next_req_fc = req_fc_o;
      next_req_addr = req_addr_o;
      next_req_data = req_data_o;
      next_exc = exc_code_o;
      case (fst)
         mbx_pkg::FR_IDLE: if (rdone) begin
            next_fbuf[0] = rsh;
            next_flen = 4'h1;
            next_fcrc = mbx_pkg::mbx_crc_byte(mbx_pkg::CRC_INIT, rsh);
            next_gcnt = GAP_LAST;
            next_fst = mbx_pkg::FR_RECV;
         end
         mbx_pkg::FR_RECV: if (rdone) begin
            if (flen < mbx_pkg::FRAME_LEN) begin
               next_fbuf[flen[2:0]] = rsh;
            end
            if (flen != mbx_pkg::LEN_SAT) begin
               next_flen = flen + 4'h1;
            end
            next_fcrc = mbx_pkg::mbx_crc_byte(fcrc, rsh);
            next_gcnt = GAP_LAST;
         end else if (rx_st != mbx_pkg::RX_IDLE) begin
            next_gcnt = GAP_LAST;
         end else if (gcnt == '0) begin
            next_fst = mbx_pkg::FR_EVAL;
         end else begin
            next_gcnt = gcnt - CW'(1);
         end
         mbx_pkg::FR_EVAL: if (discard) begin
            next_fst = mbx_pkg::FR_IDLE;
         end else if (code == mbx_pkg::EXC_NONE) begin
            next_req_ok = 1'b1;
            next_req_fc = fbuf[1];
            next_req_addr = raddr;
            next_req_data = rdata;
            next_fst = mbx_pkg::FR_IDLE;
         end else begin
            next_rep[0] = fbuf[0];
            next_rep[1] = fbuf[1] | mbx_pkg::EXC_FLAG;
            next_rep[2] = code;
            next_rep[3] = rep_crc[7:0]; // crc low byte first
            next_rep[4] = rep_crc[15:8];
            next_exc = code;
            next_pidx = 3'h0;
            next_fst = mbx_pkg::FR_PUSH;
         end
         mbx_pkg::FR_PUSH: if (fifo_in_ready) begin
            if (pidx == mbx_pkg::REPLY_LAST) begin
               next_fst = mbx_pkg::FR_WAIT;
            end else begin
               next_pidx = pidx + 3'h1;
            end
         end
         mbx_pkg::FR_WAIT: if (!fifo_out_valid && tst == mbx_pkg::TX_IDLE) begin
            next_fst = mbx_pkg::FR_IDLE;
         end
         default: next_fst = mbx_pkg::FR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         fst <= mbx_pkg::FR_IDLE;
         for (int i = 0; i < 8; i++) begin
            fbuf[i] <= 8'h00;
         end
         for (int i = 0; i < 5; i++) begin
            rep[i] <= 8'h00;
         end
         flen <= 4'h0;
         fcrc <= mbx_pkg::CRC_INIT;
         gcnt <= '0;
         pidx <= 3'h0;
         req_ok_o <= 1'b0;
         req_fc_o <= 8'h00;
         req_addr_o <= 16'h0000;
         req_data_o <= 16'h0000;
         exc_code_o <= mbx_pkg::EXC_NONE;
      end else begin
         fst <= next_fst;
         fbuf <= next_fbuf;
         rep <= next_rep;
         flen <= next_flen;
         fcrc <= next_fcrc;
         gcnt <= next_gcnt;
         pidx <= next_pidx;
         req_ok_o <= next_req_ok;
         req_fc_o <= next_req_fc;
         req_addr_o <= next_req_addr;
         req_data_o <= next_req_data;
         exc_code_o <= next_exc;
      end
   end

   // ============================================================
   // reply queue; a stalled transmitter holds the builder in push
   mbx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(ref_clk_i),
      .rst_i(sys_rst_i),
      .in_valid_i(fst == mbx_pkg::FR_PUSH),
      .in_ready_o(fifo_in_ready),
      .in_data_i(rep[pidx]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // ============================================================
   // transmitter
   logic [CW-1:0] tcnt, next_tcnt;
   logic [2:0] tbit, next_tbit;
   logic [7:0] tsh, next_tsh;
   logic next_tx, next_de;

   assign fifo_out_ready = (tst == mbx_pkg::TX_IDLE);

   // 8n1 framing; driver stays on while anything is queued
   always_comb begin
      next_tst = tst;
      next_tcnt = tcnt;
      next_tbit = tbit;
      next_tsh = tsh;
      next_tx = tx_o;
      case (tst)
         mbx_pkg::TX_IDLE: if (fifo_out_valid) begin
            next_tsh = fifo_out_data;
            next_tcnt = BIT_LAST;
            next_tx = 1'b0;
            next_tst = mbx_pkg::TX_START;
         end
         mbx_pkg::TX_START: if (tcnt == '0) begin
            next_tx = tsh[0];
            next_tcnt = BIT_LAST;
            next_tbit = 3'h0;
            next_tst = mbx_pkg::TX_DATA;
         end else begin
            next_tcnt = tcnt - CW'(1);
         end
         mbx_pkg::TX_DATA: if (tcnt == '0) begin
            next_tcnt = BIT_LAST;
            next_tsh = {1'b1, tsh[7:1]};
            if (tbit == 3'h7) begin
               next_tx = 1'b1;
               next_tst = mbx_pkg::TX_STOP;
            end else begin
               next_tx = tsh[1];
               next_tbit = tbit + 3'h1;
            end
         end else begin
            next_tcnt = tcnt - CW'(1);
         end
         mbx_pkg::TX_STOP: if (tcnt == '0) begin
            next_tst = mbx_pkg::TX_IDLE;
         end else begin
            next_tcnt = tcnt - CW'(1);
         end
         default: next_tst = mbx_pkg::TX_IDLE;
      endcase
      next_de = next_tst != mbx_pkg::TX_IDLE || fifo_out_valid || fst == mbx_pkg::FR_PUSH;
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         tst <= mbx_pkg::TX_IDLE;
         tcnt <= '0;
         tbit <= 3'h0;
         tsh <= 8'h00;
         tx_o <= 1'b1;
         de_o <= 1'b0;
      end else begin
         tst <= next_tst;
         tcnt <= next_tcnt;
         tbit <= next_tbit;
         tsh <= next_tsh;
         tx_o <= next_tx;
         de_o <= next_de;
      end
   end

   // ============================================================
   // checks
   logic chk_eval;
   assign chk_eval = fst == mbx_pkg::FR_EVAL && !discard;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_unsup_func: assert property (chk_eval && !is_read && !is_write |=>
      exc_code_o == 8'h01 && fst == mbx_pkg::FR_PUSH) else $error("unsupported code not 01");
   a_bad_addr: assert property (chk_eval && is_write && flen == 4'h8 && !addr_ok(raddr) |=>
      exc_code_o == 8'h02 && !req_ok_o) else $error("bad address not 02");
   a_ro_write: assert property (chk_eval && is_write && flen == 4'h8 && addr_ok(raddr) &&
      raddr != mbx_pkg::REG_CTRL && !is_param(raddr) |=> exc_code_o == 8'h03)
      else $error("read-only write not 03");
   a_run_refuse: assert property (chk_eval && is_write && flen == 4'h8 && is_param(raddr) &&
      motor_run_i |=> !req_ok_o && exc_code_o == 8'h03) else $error("write while running taken");
   a_flag_echo: assert property (fst == mbx_pkg::FR_PUSH && pidx == 3'h1 |->
      rep[1] == (fbuf[1] | 8'h80) && rep[0] == fbuf[0]) else $error("function code not flagged");
   a_in_addr: assert property (chk_eval && fbuf[1] == 8'h04 && flen == 4'h8 &&
      rdata <= READ_MAX && !addr_ok(raddr) |=> rep[1] == 8'h84 && rep[2] == 8'h02)
      else $error("code 04 bad address reply wrong");
   a_big_count: assert property (chk_eval && fbuf[1] == 8'h04 && flen == 4'h8 &&
      rdata > READ_MAX |=> rep[1] == 8'h84 && rep[2] == 8'h03) else $error("large count not 03");
   a_frame_len: assert property (req_ok_o |-> $past(flen) == 4'h8)
      else $error("accepted frame not eight bytes");
   a_bit_hold: assert property (tst != mbx_pkg::TX_IDLE && tcnt != '0 |=> $stable(tx_o))
      else $error("line changed inside a bit");
   a_two_codes: assert property (req_ok_o |->
      req_fc_o == 8'h03 || req_fc_o == 8'h06) else $error("other code accepted");
   a_silent_drop: assert property (fst == mbx_pkg::FR_EVAL && discard |=>
      fst == mbx_pkg::FR_IDLE && !req_ok_o && !de_o) else $error("bad frame answered");

   c_exception: cover property (fst == mbx_pkg::FR_WAIT ##1 fst == mbx_pkg::FR_IDLE);
   c_accept: cover property (req_ok_o);
   c_drop: cover property (fst == mbx_pkg::FR_EVAL && discard);
   c_fifo_full: cover property (fst == mbx_pkg::FR_PUSH && !fifo_in_ready);
endmodule
`default_nettype wire

// file: src/mbx_pkg.sv
// ============================================================
// shared constants for the exception responder
package mbx_pkg;

   // ============================================================
   // line timing
   localparam int CLK_HZ = 125_000_000;
   localparam int BAUD_HZ = 9600;
   localparam int CHAR_BITS = 10; // start, eight data, stop
   localparam int GAP_TENTHS = 35; // end of frame after 3.5 quiet characters
   localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
   localparam int GAP_CYC = BIT_CYC * CHAR_BITS * GAP_TENTHS / 10;
   localparam int CNT_W = 20;

   // ============================================================
   // frame layout
   localparam logic [3:0] FRAME_LEN = 4'h8;
   localparam logic [3:0] MIN_LEN = 4'h4;
   localparam logic [3:0] LEN_SAT = 4'hf;
   localparam logic [2:0] REPLY_LAST = 3'h4;

   // ============================================================
   // function and exception codes
   localparam logic [7:0] FC_READ = 8'h03;
   localparam logic [7:0] FC_READ_IN = 8'h04;
   localparam logic [7:0] FC_WRITE = 8'h06;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;

   // ============================================================
   // register addresses, relative to the holding register base
   localparam logic [15:0] REG_CTRL = 16'h0001;
   localparam logic [15:0] REG_FAULT = 16'h0004;
   localparam logic [15:0] REG_PARAM_LO = 16'h0100;
   localparam logic [15:0] REG_PARAM_HI = 16'h0111;
   localparam logic [15:0] REG_RATED_I = 16'h0112;
   localparam logic [15:0] REG_RATED_U = 16'h0113;
   localparam logic [15:0] REG_POWER_U = 16'h0122;
   localparam logic [15:0] CTRL_USED = 16'h0007;
   localparam logic [15:0] ONE_WORD = 16'h0001;

   // ============================================================
   // crc-16, reflected
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] CRC_GOOD = 16'h0000;

   // ============================================================
   // state encodings
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
   } mbx_rx_t;
   typedef enum logic [4:0] {
      FR_IDLE = 5'b00001, FR_RECV = 5'b00010, FR_EVAL = 5'b00100,
      FR_PUSH = 5'b01000, FR_WAIT = 5'b10000
   } mbx_fr_t;
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100, TX_STOP = 4'b1000
   } mbx_tx_t;

   // one byte through the crc, low bit first
   function automatic logic [15:0] mbx_crc_byte(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

endpackage

// file: src/mbx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// small byte fifo between reply builder and transmitter
module mbx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [WIDTH-1:0] next_mem [0:DEPTH-1];
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [CW-1:0] count, next_count;
   logic push, pop;

   // full and empty come straight from the count
   assign in_ready_o = (count != CNT_FULL);
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // pointer and storage update
   always_comb begin
      next_mem = mem;
      next_wptr = wptr;
      next_rptr = rptr;
      next_count = count;
      if (push) begin
         next_mem[wptr] = in_data_i;
         next_wptr = (wptr == PTR_LAST) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
         next_rptr = (rptr == PTR_LAST) ? '0 : rptr + AW'(1);
      end
      if (push && !pop) begin
         next_count = count + CW'(1);
      end else if (pop && !push) begin
         next_count = count - CW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         mem <= next_mem;
      end
   end
endmodule
`default_nettype wire

// file: verification/mbx_master.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// master station model on the rs485 pair
module mbx_master #(
   parameter int BIT = 16
) (
   // clock
   input wire logic clk_i,
   // line
   output logic rx_o,
   input wire logic tx_i
);
   initial rx_o = 1'b1;
   // reflected crc-16 over the first n bytes
   function automatic logic [15:0] crc(input logic [7:0] q[$], input int n);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i < n; i++) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      return c;
   endfunction
   // 8n1, low bit first, idle high between characters
   task automatic put(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_o <= f[i];
         repeat (BIT) @(negedge clk_i);
      end
   endtask
   // frame plus crc, low byte first; bad flips one crc bit
   task automatic send(input logic [7:0] q[$], input bit bad);
      logic [15:0] c;
      c = crc(q, q.size()) ^ {15'h0000, bad};
      @(negedge clk_i);
      foreach (q[i]) put(q[i]);
      put(c[7:0]);
      put(c[15:8]);
   endtask
   // collect up to five reply bytes; empty when the line stays quiet
   task automatic recv(output logic [7:0] q[$]);
      int w;
      logic [7:0] b;
      q = {};
      for (int n = 0; n < 5; n++) begin
         w = 0;
         while (tx_i !== 1'b0 && w < 40 * BIT) begin
            @(negedge clk_i);
            w++;
         end
         if (w >= 40 * BIT) return;
         repeat (BIT / 2) @(negedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk_i);
            b[i] = tx_i;
         end
         repeat (BIT) @(negedge clk_i);
         if (tx_i !== 1'b1) return;
         q.push_back(b);
      end
   endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// testbench for the exception responder
module tb;
   localparam int BIT = 16;
   logic ref_clk_i, sys_rst_i, motor_run_i, rx_i, tx_o, de_o, req_ok_o;
   logic [7:0] slave_addr_i, req_fc_o, exc_code_o, fd, a;
   logic [15:0] req_addr_o, req_data_o;
   int num_errors, cmp_count;
   int ok_cnt = 0;
   mbx_responder #(.BIT_CYC(BIT), .GAP_CYC(200)) DUT (.ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i), .slave_addr_i(slave_addr_i), .motor_run_i(motor_run_i),
      .rx_i(rx_i), .tx_o(tx_o), .de_o(de_o), .req_ok_o(req_ok_o), .req_fc_o(req_fc_o),
      .req_addr_o(req_addr_o), .req_data_o(req_data_o), .exc_code_o(exc_code_o));
   mbx_master #(.BIT(BIT)) m (.clk_i(ref_clk_i), .rx_o(rx_i), .tx_i(tx_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   // accepted-request pulses, counted so a single pulse is never missed
   always @(posedge ref_clk_i) if (req_ok_o === 1'b1) ok_cnt <= ok_cnt + 1;
   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask
   // one frame out, reply or silence back; exc 00 means no reply expected
   task automatic run(input logic [7:0] f[$], input bit bad, input logic [7:0] exc, input bit ok);
      logic [7:0] q[$];
      logic [15:0] c;
      int n, w;
      n = ok_cnt;
      m.send(f, bad);
      m.recv(q);
      @(negedge ref_clk_i);
      check("reply length", (exc != 8'h00) ? 16'h0005 : 16'h0000, 16'(q.size()));
      if (q.size() == 5) begin
         c = m.crc(q, 3);
         check("reply addr", {8'h00, slave_addr_i}, {8'h00, q[0]});
         check("reply fc", {8'h00, f[1] | 8'h80}, {8'h00, q[1]});
         check("reply code", {8'h00, exc}, {8'h00, q[2]});
         check("reply crc", c, {q[4], q[3]});
         check("exc_code_o", {8'h00, exc}, {8'h00, exc_code_o});
         check("de_o", 16'h0001, {15'h0000, de_o});
      end
      check("req_ok count", ok ? 16'h0001 : 16'h0000, 16'(ok_cnt - n));
      if (ok) check("req_fc", {8'h00, f[1]}, {8'h00, req_fc_o});
      if (ok) check("req_data", {f[4], f[5]}, req_data_o);
      if (ok) check("req_addr", {f[2], f[3]}, req_addr_o);
      w = 0;
      while (de_o !== 1'b0 && w < 4 * BIT) begin
         @(negedge ref_clk_i);
         w++;
      end
      if (w >= 4 * BIT) begin
         num_errors++;
         final_report();
      end
      $display("test fc %h done", f[1]);
   endtask
   initial begin
      num_errors = 0;
      cmp_count = 0;
      slave_addr_i = 8'($urandom(32'h3e109822));
      a = slave_addr_i;
      sys_rst_i = 1'b1;
      motor_run_i = 1'b0;
      fd = 8'h00;
      repeat (2) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      // idle line, driver off and no exception right after reset
      @(negedge ref_clk_i);
      check("de_o reset", 16'h0000, {15'h0000, de_o});
      check("tx_o reset", 16'h0001, {15'h0000, tx_o});
      check("exc_code_o reset", 16'h0000, {8'h00, exc_code_o});
      run({a, 8'h08, 8'h00, 8'h80, 8'h00, 8'h0d}, 0, 8'h01, 0);
      run({a, 8'h04, 8'h01, 8'h80, 8'h00, 8'h07}, 0, 8'h02, 0);
      run({a, 8'h04, 8'h01, 8'h80, 8'h01, 8'h80}, 0, 8'h03, 0);
      motor_run_i = 1'b1;
      run({a, 8'h06, 8'h01, 8'h05, 8'h00, 8'hfa}, 0, 8'h03, 0);
      run({a, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02}, 0, 8'h00, 1);
      motor_run_i = 1'b0;
      run({a, 8'h06, 8'h02, 8'h00, 8'h00, 8'h01}, 0, 8'h02, 0);
      run({a, 8'h06, 8'h00, 8'h02, 8'h00, 8'h01}, 0, 8'h03, 0);
      run({a, 8'h06, 8'h00, 8'h01, 8'h00, 8'h08}, 0, 8'h03, 0);
      run({a, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02}, 0, 8'h03, 0);
      run({a, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01}, 0, 8'h01, 0);
      run({a, 8'h06, 8'h01, 8'h05, 8'h00, 8'hfa}, 0, 8'h00, 1);
      run({a, 8'h06, 8'h01, 8'h00, 8'h03, 8'he9}, 0, 8'h03, 0);
      run({a, 8'h06, 8'h01, 8'h00, 8'h03, 8'he8}, 0, 8'h00, 1);
      run({a, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 0, 8'h00, 1);
      run({a, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01}, 1, 8'h00, 0);
      run({a ^ 8'h01, 8'h08, 8'h00, 8'h80, 8'h00, 8'h0d}, 0, 8'h00, 0);
      // random unsupported codes, steered off the two served ones and 04
      for (int i = 0; i < 3; i++) begin
         fd = 8'($urandom);
         if (fd == 8'h03 || fd == 8'h04 || fd == 8'h06) fd = fd ^ 8'h10;
         run({a, fd, 8'($urandom), 8'($urandom), 8'h00, 8'h01}, 0, 8'h01, 0);
      end
      final_report();
   end
endmodule
`default_nettype wire
